//--- common/baro_pkg.sv
// package of constants and carrier types for the barometer readout block
package baro_pkg;
   // ==========================================================
   // i2c addressing and commands
   localparam logic [6:0] DEV_ADDR       = 7'h6D;
   localparam logic [7:0] REG_MEAS       = 8'h30;
   localparam logic [7:0] CMD_MEAS       = 8'h0A;
   localparam logic [7:0] REG_FETCH      = 8'h06;
   // ==========================================================
   // result packet layout
   localparam int         PKT_BYTES      = 5;
   localparam int         PRESS_W        = 24;
   localparam int         TEMP_W         = 16;
   localparam logic [23:0] PRESS_RESET   = 24'h000000;
   localparam logic [15:0] TEMP_RESET    = 16'h0000;
   // ==========================================================
   // timing
   localparam int         CLK_MHZ        = 200;
   localparam int         CONV_US        = 2500;
   localparam int         CONV_CYCLES    = CONV_US * CLK_MHZ;
   // ==========================================================
   // carrier types
   typedef struct packed {
      logic [23:0] press;
      logic [15:0] temp;
   } baro_result_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } baro_link_t;

   typedef enum {
      BARO_SLEEP,
      BARO_TEMP,
      BARO_PRESS
   } baro_meas_t;
endpackage

//--- design/baro_sync.sv
// two-flop synchroniser for pins entering the clock domain
`timescale 1ns/10ps
module baro_sync #(
   parameter int WIDTH = 2
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   // asynchronous input and synchronised output
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   // ==========================================================
   // two stages, reset to idle-high levels
   always_ff @(posedge clk) begin
      if (rst) begin
         meta     <= '1;
         sync_out <= '1;
      end else if (ce) begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule

//--- design/baro_readout.sv
// i2c target, measurement sequencer and result packet shifter
`timescale 1ns/10ps
// Contract
// - sleep after reset until measurement request
// - request runs one cycle, stores, sleeps
// - select pin high or open selects i2c
// - answer only target address 0x6D
// - fetch never measures, returns stored results
// - copy packet to shifter after read address
// - shifter frozen until transfer ends
// - pressure always presented as 24 bits
// - bytes and bits sent msb first
// - sensor powered only during conversion
// - fetch returns three pressure, two temperature
// - temperature then pressure, about 5 ms
// - temperature is 16-bit two's complement
module baro_readout #(
   parameter int CONV_CYCLES = baro_pkg::CONV_CYCLES
) (
   // clock, reset, enable
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic                 ce,
   // i2c pins
   input  wire logic                 scl,
   input  wire logic                 sda_in,
   output logic                      sda_out,
   output logic                      sda_oe,
   // interface select pin, pulled up on the pad
   input  wire logic                 interface_select_pin,
   // converter side
   input  wire baro_pkg::baro_result_t conv_data,
   output logic                      sensor_power,
   output logic                      meas_busy
);
   // refuse a conversion length the phase counter cannot serve
   if (CONV_CYCLES < 2) begin : g_conv_check
      $error("CONV_CYCLES too small");
   end

   // ==========================================================
   // pin synchronisation
   logic [2:0] pins_s;
   baro_sync #(.WIDTH(3)) u_sync (
      .clk      (clk),
      .rst      (rst),
      .ce       (ce),
      .async_in ({scl, sda_in, interface_select_pin}),
      .sync_out (pins_s)
   );

   logic scl_q;
   logic sda_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else if (ce) begin
         scl_q <= pins_s[2];
         sda_q <= pins_s[1];
      end
   end

   // ==========================================================
   // bus event decode
   wire scl_s     = pins_s[2];
   wire sda_s     = pins_s[1];
   wire i2c_mode  = pins_s[0];
   wire scl_rise  = scl_s & ~scl_q;
   wire scl_fall  = ~scl_s & scl_q;
   wire start_ev  = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_ev   = scl_s & scl_q & ~sda_q & sda_s;

   // ==========================================================
   // target state machine
   typedef enum {
      T_IDLE,
      T_START,
      T_ADDR,
      T_ADDR_ACK,
      T_WBYTE,
      T_WACK,
      T_RBYTE,
      T_RACK
   } baro_tgt_t;

   baro_tgt_t       tgt;
   baro_tgt_t       next_tgt;
   logic [7:0]      shreg;
   logic [2:0]      bitcnt;
   logic            rd_dir;
   logic [1:0]      wcount;
   logic [7:0]      reg_ptr;
   logic            meas_req;
   logic [39:0]     out_pkt;
   logic            in_xfer;
   baro_pkg::baro_result_t result;

   wire addr_match = (shreg[7:1] == baro_pkg::DEV_ADDR);
   wire byte_done  = (bitcnt == 3'd7);
   wire is_cmd     = (reg_ptr == baro_pkg::REG_MEAS) && (shreg == baro_pkg::CMD_MEAS);

   // next state on scl falling edge
   always_comb begin
      next_tgt = tgt;
      case (tgt)
         T_START:    next_tgt = T_ADDR;                 // scl fall closing the start condition
         T_ADDR:     next_tgt = byte_done ? (addr_match ? T_ADDR_ACK : T_IDLE) : T_ADDR;
         T_ADDR_ACK: next_tgt = rd_dir ? T_RBYTE : T_WBYTE;
         T_WBYTE:    next_tgt = byte_done ? T_WACK : T_WBYTE;
         T_WACK:     next_tgt = T_WBYTE;
         T_RBYTE:    next_tgt = byte_done ? T_RACK : T_RBYTE;
         T_RACK:     next_tgt = T_RBYTE;
         default:    next_tgt = T_IDLE;
      endcase
   end

   // target sequencing and receive shift
   always_ff @(posedge clk) begin
      if (rst) begin
         tgt     <= T_IDLE;
         shreg   <= 8'h00;
         bitcnt  <= 3'd0;
         rd_dir  <= 1'b0;
         wcount  <= 2'd0;
         reg_ptr <= 8'h00;
         in_xfer <= 1'b0;
      end else if (ce) begin
         if (!i2c_mode || stop_ev) begin
            tgt     <= T_IDLE;
            in_xfer <= 1'b0;
         end else if (start_ev) begin
            tgt    <= T_START;                                  // the fall after start carries no bit
            bitcnt <= 3'd0;
            wcount <= 2'd0;
         end else if (scl_rise && (tgt == T_ADDR || tgt == T_WBYTE)) begin
            shreg <= {shreg[6:0], sda_s};
         end else if (scl_rise && tgt == T_RACK && sda_s) begin
            tgt <= T_IDLE;
         end else if (scl_fall && tgt != T_IDLE) begin
            tgt    <= next_tgt;
            bitcnt <= (tgt == T_ADDR || tgt == T_WBYTE || tgt == T_RBYTE) ? bitcnt + 3'd1 : 3'd0;
            if (tgt == T_ADDR && byte_done) begin
               rd_dir  <= shreg[0];
               in_xfer <= addr_match;
            end
            if (tgt == T_WBYTE && byte_done) begin
               if (wcount == 2'd0) begin
                  reg_ptr <= shreg;
               end
               wcount <= (wcount == 2'd3) ? wcount : wcount + 2'd1;
            end
         end
      end
   end

   // measurement request decode, second write byte after pointer 0x30
   always_ff @(posedge clk) begin
      if (rst) begin
         meas_req <= 1'b0;
      end else if (ce) begin
         meas_req <= scl_fall && tgt == T_WBYTE && byte_done && wcount == 2'd1 && is_cmd;
      end
   end

   // ==========================================================
   // output packet: load at read address, freeze for transfer
   wire load_pkt = scl_fall && tgt == T_ADDR && byte_done && addr_match && shreg[0];
   always_ff @(posedge clk) begin
      if (rst) begin
         out_pkt <= {baro_pkg::PRESS_RESET, baro_pkg::TEMP_RESET};
      end else if (ce) begin
         if (load_pkt) begin
            out_pkt <= {result.press, result.temp};
         end else if (scl_fall && tgt == T_RBYTE) begin
            out_pkt <= {out_pkt[38:0], out_pkt[39]};
         end
      end
   end

   // sda drive: ack slots and read data, open drain
   always_ff @(posedge clk) begin
      if (rst) begin
         sda_oe <= 1'b0;
      end else if (ce) begin
         if (stop_ev || start_ev || !i2c_mode) begin
            sda_oe <= 1'b0;
         end else if (scl_fall) begin
            case (next_tgt)
               T_ADDR_ACK: sda_oe <= (tgt == T_ADDR);
               T_WACK:     sda_oe <= 1'b1;
               T_RBYTE:    sda_oe <= ~(load_pkt ? 1'b1 : (tgt == T_RACK || tgt == T_ADDR_ACK ?
                                       out_pkt[39] : out_pkt[38]));
               default:    sda_oe <= 1'b0;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sda_out <= 1'b0;
      end else if (ce) begin
         sda_out <= 1'b0;
      end
   end

   // ==========================================================
   // measurement sequencer: temperature then pressure
   baro_pkg::baro_meas_t meas;
   logic [31:0]          conv_cnt;
   logic [15:0]          temp_hold;
   wire conv_end = (conv_cnt == 32'(CONV_CYCLES - 1));

   always_ff @(posedge clk) begin
      if (rst) begin
         meas     <= baro_pkg::BARO_SLEEP;
         conv_cnt <= 32'h0;
         temp_hold <= baro_pkg::TEMP_RESET;
         result   <= {baro_pkg::PRESS_RESET, baro_pkg::TEMP_RESET};
      end else if (ce) begin
         case (meas)
            baro_pkg::BARO_SLEEP: begin
               conv_cnt <= 32'h0;
               if (meas_req) meas <= baro_pkg::BARO_TEMP;
            end
            baro_pkg::BARO_TEMP: begin
               conv_cnt <= conv_end ? 32'h0 : conv_cnt + 32'h1;
               if (conv_end) begin
                  temp_hold <= conv_data.temp;
                  meas      <= baro_pkg::BARO_PRESS;
               end
            end
            default: begin
               conv_cnt <= conv_end ? 32'h0 : conv_cnt + 32'h1;
               // commit both values together so a fetch never sees a torn packet
               if (conv_end) begin
                  result <= {conv_data.press, temp_hold};
                  meas   <= baro_pkg::BARO_SLEEP;
               end
            end
         endcase
      end
   end

   // sensor supply and busy flag straight from flops
   always_ff @(posedge clk) begin
      if (rst) begin
         sensor_power <= 1'b0;
         meas_busy    <= 1'b0;
      end else if (ce) begin
         sensor_power <= (meas != baro_pkg::BARO_SLEEP) && !(meas == baro_pkg::BARO_PRESS && conv_end);
         meas_busy    <= (meas != baro_pkg::BARO_SLEEP) && !(meas == baro_pkg::BARO_PRESS && conv_end);
      end
   end

   // ==========================================================
   // assertions
   a_sleep_idle: assert property (@(posedge clk) disable iff (rst)
      (meas == baro_pkg::BARO_SLEEP && !meas_req && ce) |=> meas == baro_pkg::BARO_SLEEP)
      else $error("left sleep without request");
   a_req_wakes: assert property (@(posedge clk) disable iff (rst)
      (meas == baro_pkg::BARO_SLEEP && meas_req && ce) |=> meas == baro_pkg::BARO_TEMP)
      else $error("request did not wake");
   a_power_meas: assert property (@(posedge clk) disable iff (rst)
      ce |=> sensor_power == $past(meas != baro_pkg::BARO_SLEEP && !(meas == baro_pkg::BARO_PRESS && conv_end)))
      else $error("sensor power mismatch");
   a_busy_ignore: assert property (@(posedge clk) disable iff (rst)
      (meas == baro_pkg::BARO_PRESS && !conv_end && ce) |=> meas == baro_pkg::BARO_PRESS)
      else $error("cycle disturbed");
   a_no_ack_other: assert property (@(posedge clk) disable iff (rst)
      (ce && scl_fall && tgt == T_ADDR && byte_done && !addr_match) |=> !sda_oe && tgt == T_IDLE)
      else $error("acked foreign address");
   a_mode_sel: assert property (@(posedge clk) disable iff (rst)
      (ce && !i2c_mode) |=> tgt == T_IDLE)
      else $error("i2c active while deselected");
   a_result_hold: assert property (@(posedge clk) disable iff (rst)
      (meas == baro_pkg::BARO_SLEEP) |=> result == $past(result))
      else $error("results changed without measurement");
   a_pkt_frozen: assert property (@(posedge clk) disable iff (rst)
      (ce && in_xfer && tgt != T_RBYTE && !load_pkt) |=> out_pkt == $past(out_pkt))
      else $error("packet changed in transfer");
   a_pkt_load: assert property (@(posedge clk) disable iff (rst)
      (ce && load_pkt) |=> out_pkt == {$past(result.press), $past(result.temp)})
      else $error("packet not loaded at read address");
endmodule

//--- testbench/baro_host_model.sv
// behavioural i2c host that drives the bus for the bench
`timescale 1ns/10ps
module baro_host_model (
   // bus lines
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   // quarter of the 48 ns link clock period
   localparam time Q = 12;
   // bus idle: both lines released, scl stands still high
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end
   // start or repeated start: sda falls while scl is high
   task automatic start();
      // wait out the target's ack hold before raising scl for a repeated start
      #Q sda_low = 1'b0;
      #Q scl = 1'b1;
      #Q sda_low = 1'b1;
      #Q scl = 1'b0;
   endtask
   // stop: sda rises while scl is high, scl then rests high
   task automatic stop();
      #Q sda_low = 1'b1;
      #Q scl = 1'b1;
      #Q sda_low = 1'b0;
      #(2*Q);
   endtask
   // one bit: data set while scl low, sampled in the middle of scl high
   task automatic bit_io(input logic b, output logic r);
      #Q sda_low = ~b;
      #Q scl = 1'b1;
      #Q r = sda;
      #Q scl = 1'b0;
   endtask
   // byte written msb first, ninth bit returns the target acknowledge
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // byte read msb first, host acks all but the last one
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask
endmodule

//--- testbench/tb_barometer_i2c_readout.sv
// self-checking bench for the barometer readout block
`timescale 1ns/10ps
module tb_barometer_i2c_readout;
   // ==========================================================
   // signals
   localparam int          CONV = 200;
   logic                   clk, rst, ce, isp, sda_out, sda_oe, sensor_power, meas_busy, scl, host_low;
   wire                    sda;
   baro_pkg::baro_result_t conv_data, got;
   baro_pkg::baro_result_t val_a, val_b;
   int                     n_fail, checked, cyc;
   logic                   a1, a2, a3;
   // open-drain bus with pull-up
   assign sda = ~(host_low | (sda_oe & ~sda_out));
   baro_readout #(.CONV_CYCLES(CONV)) uut (.clk(clk), .rst(rst), .ce(ce), .scl(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .interface_select_pin(isp), .conv_data(conv_data),
      .sensor_power(sensor_power), .meas_busy(meas_busy));
   baro_host_model host (.scl(scl), .sda_low(host_low), .sda(sda));
   // clock
   always #2.5 clk = ~clk;
   // cycle count and hang limit
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         n_fail = n_fail + 1;
         summarize();
      end
   end
   // ==========================================================
   // compare, verdict and bus tasks
   task automatic chk1(input string name, input logic exp, input logic seen);
      checked++;
      if (seen !== exp) begin
         $display("BAD %s exp %h got %h", name, exp, seen);
         n_fail++;
      end
   endtask
   task automatic chkr(input string name, input baro_pkg::baro_result_t exp, input baro_pkg::baro_result_t seen);
      checked++;
      if (seen !== exp) begin
         $display("BAD %s exp %h got %h", name, exp, seen);
         n_fail++;
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // measurement request: address write, register, command, stop
   task automatic request();
      host.start();
      host.wr_byte({baro_pkg::DEV_ADDR, 1'b0}, a1);
      host.wr_byte(baro_pkg::REG_MEAS, a2);
      host.wr_byte(baro_pkg::CMD_MEAS, a3);
      host.stop();
   endtask
   // fetch: register write, repeated start, five bytes, nack and stop
   task automatic fetch(output baro_pkg::baro_result_t r);
      logic [7:0] b;
      logic [2:0] ak;
      host.start();
      host.wr_byte({baro_pkg::DEV_ADDR, 1'b0}, ak[0]);
      host.wr_byte(baro_pkg::REG_FETCH, ak[1]);
      host.start();
      host.wr_byte({baro_pkg::DEV_ADDR, 1'b1}, ak[2]);
      for (int i = 0; i < baro_pkg::PKT_BYTES; i++) begin
         host.rd_byte(i == baro_pkg::PKT_BYTES - 1, b);
         r = {r[31:0], b};
      end
      host.stop();
      chk1("fetch acks", 1'b1, &ak);
   endtask
   task automatic wait_busy(input logic v, input int max);
      int i;
      i = 0;
      while (meas_busy !== v && i < max) begin
         @(negedge clk);
         i++;
      end
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset();
      chk1("busy", 1'b0, meas_busy);
      chk1("power", 1'b0, sensor_power);
      fetch(got);
      chkr("reset packet", {baro_pkg::PRESS_RESET, baro_pkg::TEMP_RESET}, got);
      chk1("busy after fetch", 1'b0, meas_busy);
      $display("test reset done");
   endtask
   task automatic t_address();
      host.start();
      host.wr_byte({7'h6C, 1'b0}, a1);
      host.stop();
      chk1("other address ack", 1'b0, a1);
      @(negedge clk);
      isp = 1'b0;
      host.start();
      host.wr_byte({baro_pkg::DEV_ADDR, 1'b0}, a1);
      host.stop();
      chk1("deselected ack", 1'b0, a1);
      @(negedge clk);
      isp = 1'b1;
      $display("test address done");
   endtask
   task automatic t_measure();
      request();
      chk1("req acks", 1'b1, a1 & a2 & a3);
      chk1("busy", 1'b1, meas_busy);
      chk1("power", 1'b1, sensor_power);
      wait_busy(1'b0, 2 * CONV + 20);
      chk1("busy end", 1'b0, meas_busy);
      chk1("power off", 1'b0, sensor_power);
      fetch(got);
      chkr("packet", val_a, got);
      @(negedge clk);
      conv_data = val_b;
      fetch(got);
      chkr("stale packet", val_a, got);
      $display("test measure done");
   endtask
   task automatic t_frozen();
      request();
      fetch(got);
      chkr("frozen packet", val_a, got);
      chk1("busy end", 1'b0, meas_busy);
      fetch(got);
      chkr("new packet", val_b, got);
      $display("test frozen done");
   endtask
   task automatic t_ignore();
      int t0;
      request();
      t0 = cyc;
      request();
      chk1("still busy", 1'b1, meas_busy);
      wait_busy(1'b0, 2 * CONV + 20);
      chk1("no restart", 1'b1, (cyc - t0) <= 2 * CONV + 10);
      $display("test ignore done");
   endtask
   // clock enable low freezes the running cycle, which then ends late
   task automatic t_hold();
      int t0;
      request();
      t0 = cyc;
      @(negedge clk);
      ce = 1'b0;
      repeat (100) @(negedge clk);
      chk1("frozen busy", 1'b1, meas_busy);
      ce = 1'b1;
      wait_busy(1'b0, 2 * CONV + 20);
      chk1("held cycle", 1'b1, (cyc - t0) > 2 * CONV + 50);
      chk1("held busy end", 1'b0, meas_busy);
      $display("test hold done");
   endtask
   // ==========================================================
   // main sequence
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      isp = 1'b1;
      n_fail = 0;
      checked = 0;
      cyc = 0;
      val_a = {24'hA1B2C3, 16'hF0E1};
      val_b = {24'h0D5E6F, 16'h1234};
      conv_data = val_a;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      t_reset();
      t_address();
      t_measure();
      t_frozen();
      t_ignore();
      t_hold();
      summarize();
   end
endmodule
